// *** hw/fns_status.sv ***
// Fieldbus node status indicators, switch decode and NMT state
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module fns_status import fns_pkg::*; #(
	parameter int SLOT_CYCLES_P = SLOT_CYCLES,
	parameter int TRAFFIC_CYCLES_P = TRAFFIC_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [6:0] address_switch_bank,
	input wire logic [1:0] rate_config_switch_bank,
	input wire logic maint_switch_off,
	input wire logic msg_sent,
	input wire logic msg_rcvd_own,
	input wire logic guard_request,
	input wire logic life_timeout,
	input wire logic ctrl_error_passive,
	input wire logic ctrl_bus_off,
	input wire logic drive_fault,
	input wire logic drive_words_disabled,
	input wire logic drive_link_down,
	output logic [6:0] node_addr,
	output logic [1:0] baud_sel,
	output logic bus_enable,
	output logic error_frame_enable,
	output logic nmt_accept,
	output logic sdo_accept,
	output logic pdo_accept,
	output logic traffic_led,
	output logic lifetime_led,
	output logic state_led,
	output logic bus_error_led,
	output logic system_fault_led
);

	// ==========================================================
	// State record
	typedef struct packed {
		logic [6:0] addr_s1;
		logic [6:0] addr_s2;
		logic [1:0] rate_s1;
		logic [1:0] rate_s2;
		logic maint_s1;
		logic maint_s2;
		logic [1:0] sample_cnt;
		logic sampled;
		logic [6:0] addr;
		logic [1:0] baud;
		fns_nmt_t nmt;
		logic [1:0] pd_cfg;
		logic [15:0] guard_time;
		logic [7:0] life_factor;
		logic guard_started;
		logic [31:0] slot_div;
		logic [31:0] slot_cnt;
		logic [2:0] slot;
		logic [31:0] traffic_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic bus_en;
		logic err_frame_en;
		logic nmt_acc;
		logic sdo_acc;
		logic pdo_acc;
		logic led_traffic;
		logic led_life;
		logic led_state;
		logic led_bus;
		logic led_sys;
	} fns_state_t;

	fns_state_t state_reg;
	fns_state_t state_next;

	// Decoded helpers
	logic wr_hit;
	logic setup;
	logic [1:0] cmd;
	logic mon_enabled;
	logic addr_ok;
	logic slot_end;
	logic flash_1s;
	logic blink_once;
	logic blink_twice;
	logic [31:0] status_word;

	// ==========================================================
	// Combinational next state
	always_comb begin
		state_next = state_reg;
		setup = psel && !penable;
		wr_hit = psel && penable && state_reg.pready && pwrite;
		cmd = CMD_NONE;
		mon_enabled = (state_reg.guard_time != GUARD_TIME_RST) &&
			(state_reg.life_factor != LIFE_FACTOR_RST);
		addr_ok = state_reg.addr != ADDR_INVALID;
		slot_end = state_reg.slot_cnt >= state_reg.slot_div - 32'h1;
		// 1 s square wave: two slots on, two off
		flash_1s = !state_reg.slot[1];
		// Eight-slot cycle for counted blinks
		blink_once = state_reg.slot == 3'h0;
		blink_twice = (state_reg.slot == 3'h0) ||
			(state_reg.slot == 3'h2);

		// Pin synchronisers
		state_next.addr_s1 = address_switch_bank;
		state_next.addr_s2 = state_reg.addr_s1;
		state_next.rate_s1 = rate_config_switch_bank;
		state_next.rate_s2 = state_reg.rate_s1;
		state_next.maint_s1 = maint_switch_off;
		state_next.maint_s2 = state_reg.maint_s1;

		// One-time switch capture after the synchronisers fill
		if (!state_reg.sampled) begin
			if (state_reg.sample_cnt == 2'(SAMPLE_DELAY - 1)) begin
				state_next.sampled = 1'b1;
				state_next.addr = state_reg.addr_s2;
				state_next.baud = state_reg.rate_s2;
			end else begin
				state_next.sample_cnt = state_reg.sample_cnt + 2'h1;
			end
		end

		// Flash slot timer
		if (slot_end) begin
			state_next.slot_cnt = 32'h0;
			state_next.slot = state_reg.slot + 3'h1;
		end else begin
			state_next.slot_cnt = state_reg.slot_cnt + 32'h1;
		end

		// Traffic pulse stretcher
		if (state_reg.bus_en && (msg_sent || msg_rcvd_own)) begin
			state_next.traffic_cnt = 32'(TRAFFIC_CYCLES_P);
		end else if (state_reg.traffic_cnt != 32'h0) begin
			state_next.traffic_cnt = state_reg.traffic_cnt - 32'h1;
		end

		// APB answer: registered one cycle after setup
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		if (setup) begin
			state_next.pready = 1'b1;
			unique case (paddr)
				OFS_CTRL: begin
					state_next.prdata = 32'h0;
					state_next.prdata[CTRL_PDCFG_LSB +: 2] =
						state_reg.pd_cfg;
				end
				OFS_GUARD_TIME: begin
					state_next.prdata = {16'h0, state_reg.guard_time};
				end
				OFS_LIFE_FACTOR: begin
					state_next.prdata = {24'h0, state_reg.life_factor};
				end
				OFS_STATUS: begin
					state_next.prdata = status_word;
				end
				OFS_SLOT_DIV: begin
					state_next.prdata = state_reg.slot_div;
				end
				default: begin
					state_next.prdata = 32'h0;
					state_next.pslverr = 1'b1;
				end
			endcase
		end else if (state_reg.pready) begin
			state_next.prdata = 32'h0;
		end

		// APB writes take effect at the completing edge
		if (wr_hit) begin
			unique case (paddr)
				OFS_CTRL: begin
					cmd = pwdata[CTRL_CMD_LSB +: 2];
					state_next.pd_cfg = pwdata[CTRL_PDCFG_LSB +: 2];
				end
				OFS_GUARD_TIME: begin
					state_next.guard_time = pwdata[15:0];
				end
				OFS_LIFE_FACTOR: begin
					state_next.life_factor = pwdata[7:0];
				end
				OFS_SLOT_DIV: begin
					if (pwdata != 32'h0) begin
						state_next.slot_div = pwdata;
					end
				end
				default: begin
				end
			endcase
		end

		// NMT state machine, commands only while on the bus
		if (state_reg.bus_en) begin
			unique case (cmd)
				CMD_START: state_next.nmt = NMT_OPER;
				CMD_STOP: state_next.nmt = NMT_STOPPED;
				CMD_PREOP: state_next.nmt = NMT_PREOP;
				default: begin
				end
			endcase
		end

		// Guarding starts on first request once monitoring is set up
		if (!mon_enabled) begin
			state_next.guard_started = 1'b0;
		end else if (guard_request && state_reg.bus_en) begin
			state_next.guard_started = 1'b1;
		end

		// Bus participation
		state_next.bus_en = state_reg.sampled && addr_ok &&
			!ctrl_bus_off;
		state_next.err_frame_en = state_next.bus_en &&
			!ctrl_error_passive;
		state_next.nmt_acc = state_next.bus_en;
		// Accepts follow the current state, in step with the state LED
		state_next.sdo_acc = state_next.bus_en &&
			(state_reg.nmt != NMT_STOPPED);
		state_next.pdo_acc = state_next.bus_en &&
			(state_reg.nmt == NMT_OPER);

		// Traffic, lifetime and state indicators
		if (state_reg.sampled && !addr_ok) begin
			state_next.led_traffic = flash_1s;
			state_next.led_life = flash_1s;
			state_next.led_state = flash_1s;
		end else begin
			state_next.led_traffic = state_reg.traffic_cnt != 32'h0;
			if (!mon_enabled || !state_reg.guard_started) begin
				state_next.led_life = 1'b0;
			end else if (life_timeout) begin
				state_next.led_life = flash_1s;
			end else begin
				state_next.led_life = 1'b1;
			end
			unique case (state_reg.nmt)
				NMT_PREOP: state_next.led_state = flash_1s;
				NMT_OPER: state_next.led_state = 1'b1;
				NMT_STOPPED: state_next.led_state = 1'b0;
			endcase
		end

		// Physical bus error indicator
		if (ctrl_bus_off) begin
			state_next.led_bus = 1'b1;
		end else if (ctrl_error_passive) begin
			state_next.led_bus = flash_1s;
		end else begin
			state_next.led_bus = 1'b0;
		end

		// System fault indicator, link loss has priority
		if (state_reg.pd_cfg != PDCFG_DRIVE) begin
			state_next.led_sys = 1'b0;
		end else if (drive_link_down || state_reg.maint_s2) begin
			state_next.led_sys = 1'b1;
		end else if (drive_words_disabled) begin
			state_next.led_sys = blink_twice;
		end else if (drive_fault) begin
			state_next.led_sys = blink_once;
		end else begin
			state_next.led_sys = 1'b0;
		end
	end

	// ==========================================================
	// Status word assembly
	always_comb begin
		status_word = 32'h0;
		status_word[ST_ADDR_LSB +: 7] = state_reg.addr;
		status_word[ST_BAUD_LSB +: 2] = state_reg.baud;
		status_word[ST_VALID_BIT] = state_reg.sampled &&
			(state_reg.addr != ADDR_INVALID);
		status_word[ST_NMT_LSB +: 2] = state_reg.nmt;
		status_word[ST_GUARD_BIT] = state_reg.guard_started;
		status_word[ST_ACTIVE_BIT] = state_reg.bus_en;
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.nmt <= NMT_PREOP;
			state_reg.pd_cfg <= PDCFG_DRIVE;
			state_reg.guard_time <= GUARD_TIME_RST;
			state_reg.life_factor <= LIFE_FACTOR_RST;
			state_reg.slot_div <= 32'(SLOT_CYCLES_P);
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign node_addr = state_reg.addr;
	assign baud_sel = state_reg.baud;
	assign bus_enable = state_reg.bus_en;
	assign error_frame_enable = state_reg.err_frame_en;
	assign nmt_accept = state_reg.nmt_acc;
	assign sdo_accept = state_reg.sdo_acc;
	assign pdo_accept = state_reg.pdo_acc;
	assign traffic_led = state_reg.led_traffic;
	assign lifetime_led = state_reg.led_life;
	assign state_led = state_reg.led_state;
	assign bus_error_led = state_reg.led_bus;
	assign system_fault_led = state_reg.led_sys;

endmodule

// *** shared/fns_pkg.sv ***
// Constants and types shared by the fieldbus node status front end
package fns_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ = 125_000_000;
	localparam int FLASH_PERIOD_MS = 1000;
	localparam int SLOTS_PER_FLASH = 4;
	localparam int SLOT_CYCLES =
		(CLK_HZ / 1000) * FLASH_PERIOD_MS / SLOTS_PER_FLASH;
	localparam int TRAFFIC_MS = 50;
	localparam int TRAFFIC_CYCLES = (CLK_HZ / 1000) * TRAFFIC_MS;
	localparam int SAMPLE_DELAY = 3;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GUARD_TIME = 8'h04;
	localparam logic [7:0] OFS_LIFE_FACTOR = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_SLOT_DIV = 8'h10;

	// ==========================================================
	// Field positions
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_PDCFG_LSB = 2;
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_BAUD_LSB = 8;
	localparam int ST_VALID_BIT = 10;
	localparam int ST_NMT_LSB = 12;
	localparam int ST_GUARD_BIT = 14;
	localparam int ST_ACTIVE_BIT = 15;

	// ==========================================================
	// Encodings and reset values
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_START = 2'h1;
	localparam logic [1:0] CMD_STOP = 2'h2;
	localparam logic [1:0] CMD_PREOP = 2'h3;
	localparam logic [1:0] PDCFG_DRIVE = 2'h0;
	localparam logic [1:0] PDCFG_IO_ONLY = 2'h1;
	localparam logic [1:0] PDCFG_INPUT_ONLY = 2'h2;
	localparam logic [1:0] BAUD_125K = 2'h0;
	localparam logic [1:0] BAUD_250K = 2'h1;
	localparam logic [1:0] BAUD_500K = 2'h2;
	localparam logic [1:0] BAUD_1M = 2'h3;
	localparam logic [6:0] ADDR_INVALID = 7'h00;
	localparam logic [15:0] GUARD_TIME_RST = 16'h0000;
	localparam logic [7:0] LIFE_FACTOR_RST = 8'h00;

	typedef enum logic [1:0] {
		NMT_PREOP,
		NMT_OPER,
		NMT_STOPPED
	} fns_nmt_t;

endpackage

// *** testbench/fns_status_asserts.sv ***
// Assertion checker for the node status front end
`timescale 1ns/100ps
module fns_status_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic msg_sent,
	input wire logic ctrl_error_passive,
	input wire logic ctrl_bus_off,
	input wire logic [6:0] node_addr,
	input wire logic [1:0] baud_sel,
	input wire logic bus_enable,
	input wire logic error_frame_enable,
	input wire logic nmt_accept,
	input wire logic sdo_accept,
	input wire logic pdo_accept,
	input wire logic traffic_led,
	input wire logic lifetime_led,
	input wire logic state_led,
	input wire logic bus_error_led
);
	logic [3:0] up_cnt;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Cycles since reset, saturating, to skip switch capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cnt <= 4'h0;
		end else if (up_cnt != 4'hF) begin
			up_cnt <= up_cnt + 4'h1;
		end
	end
	// Message seen while on the bus
	sequence s_msg;
		bus_enable && msg_sent;
	endsequence
	a_traffic_pulse: assert property (s_msg |-> ##2 traffic_led [*3])
		else $error("traffic pulse too short");
	a_addr_valid: assert property (bus_enable |-> node_addr != 7'h00)
		else $error("bus used with zero address");
	a_switch_held: assert property ($past(bus_enable) && bus_enable |->
		$stable(node_addr) && $stable(baud_sel))
		else $error("switch values moved");
	a_zero_phase: assert property (up_cnt == 4'hF && node_addr == 7'h00
		|-> traffic_led == state_led && lifetime_led == state_led)
		else $error("zero address leds out of phase");
	a_oper_accept: assert property (pdo_accept |->
		sdo_accept && nmt_accept && state_led)
		else $error("operational outputs wrong");
	a_stop_dark: assert property (nmt_accept && !sdo_accept |->
		!state_led && !pdo_accept)
		else $error("stopped outputs wrong");
	a_bus_off: assert property (ctrl_bus_off [*2] |->
		bus_error_led && !bus_enable)
		else $error("bus off not shown");
	a_err_active: assert property ((!ctrl_error_passive && !ctrl_bus_off)
		[*2] |-> !bus_error_led)
		else $error("bus led lit while error active");
	a_passive_frames: assert property (ctrl_error_passive |=>
		!error_frame_enable)
		else $error("error frames while passive");
endmodule

bind fns_status fns_status_asserts u_chk (.pclk, .presetn, .msg_sent,
	.ctrl_error_passive, .ctrl_bus_off, .node_addr, .baud_sel, .bus_enable,
	.error_frame_enable, .nmt_accept, .sdo_accept, .pdo_accept,
	.traffic_led, .lifetime_led, .state_led, .bus_error_led);

// *** testbench/fns_far_model.sv ***
// Model of the attached drive and its serial link
`timescale 1ns/100ps
module fns_far_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] cmd,
	output logic drive_fault,
	output logic drive_words_disabled,
	output logic drive_link_down,
	output logic maint_switch_off
);
	// Drive condition levels, changed only after a clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_fault <= 1'h0;
			drive_words_disabled <= 1'h0;
			drive_link_down <= 1'h0;
			maint_switch_off <= 1'h0;
		end else begin
			drive_fault <= cmd[0];
			drive_words_disabled <= cmd[1];
			drive_link_down <= cmd[2];
			maint_switch_off <= cmd[3];
		end
	end
endmodule

// *** testbench/fns_status_tb.sv ***
// Self-checking bench for the node status front end
`timescale 1ns/100ps
module fns_status_tb import fns_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] address_switch_bank, node_addr;
	logic [1:0] rate_config_switch_bank, baud_sel;
	logic msg_sent, msg_rcvd_own, guard_request, life_timeout;
	logic ctrl_error_passive, ctrl_bus_off, maint_switch_off, drive_fault;
	logic drive_words_disabled, drive_link_down, bus_enable;
	logic error_frame_enable, nmt_accept, sdo_accept, pdo_accept;
	logic traffic_led, lifetime_led, state_led, bus_error_led;
	logic system_fault_led;
	logic [3:0] cmd;
	logic [3:0] cmds [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
	int lit [4] = '{4, 8, 32, 32};
	int n_errors, n_tests, cnt;
	fns_status #(.SLOT_CYCLES_P(4), .TRAFFIC_CYCLES_P(3)) u_dut (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .address_switch_bank, .rate_config_switch_bank,
		.maint_switch_off, .msg_sent, .msg_rcvd_own, .guard_request,
		.life_timeout, .ctrl_error_passive, .ctrl_bus_off, .drive_fault,
		.drive_words_disabled, .drive_link_down, .node_addr, .baud_sel,
		.bus_enable, .error_frame_enable, .nmt_accept, .sdo_accept,
		.pdo_accept, .traffic_led, .lifetime_led, .state_led, .bus_error_led,
		.system_fault_led);
	fns_far_model u_far (.pclk, .presetn, .cmd, .drive_fault,
		.drive_words_disabled, .drive_link_down, .maint_switch_off);
	// ==========================================================
	// Helpers
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task rst(input logic [6:0] a, input logic [1:0] b);
		address_switch_bank <= a; rate_config_switch_bank <= b;
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask
	// Lit cycles of one led over a window
	task count(input int sel, input int len);
		cnt = 0;
		repeat (8) @(posedge pclk);
		repeat (len) begin
			@(posedge pclk);
			cnt += (sel == 0) ? lifetime_led : (sel == 1) ? bus_error_led :
				system_fault_led;
		end
	endtask
	task end_sim;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Clock and watchdog
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (6000) @(posedge pclk);
		n_errors++;
		end_sim;
	end
	// ==========================================================
	// Test sequence
	initial begin
		{presetn, psel, penable, pwrite, msg_sent, msg_rcvd_own} = 6'h0;
		{guard_request, life_timeout, ctrl_error_passive, ctrl_bus_off} = 4'h0;
		{paddr, pwdata, cmd} = 44'h0;
		for (int i = 0; i < 4; i++) begin
			rst(7'h09, i[1:0]);
			chk("baud", baud_sel, i);
		end
		apb(1'h0, OFS_STATUS, 32'h0);
		chk("status", rd, 32'h0000_8709);
		address_switch_bank <= 7'h7F;
		repeat (6) @(posedge pclk);
		chk("addr held", node_addr, 32'h9);
		chk("preop", {sdo_accept, pdo_accept}, 32'h2);
		chk("frames on", error_frame_enable, 32'h1);
		count(3, 0);
		$display("test switches done");
		apb(1'h1, OFS_CTRL, CMD_START);
		@(posedge pclk);
		chk("oper", {pdo_accept, state_led}, 32'h3);
		apb(1'h1, OFS_CTRL, CMD_STOP);
		@(posedge pclk);
		chk("stop", {sdo_accept, pdo_accept, state_led}, 32'h0);
		apb(1'h1, OFS_CTRL, CMD_PREOP);
		@(posedge pclk);
		chk("preop again", {sdo_accept, pdo_accept}, 32'h2);
		$display("test nmt done");
		for (int k = 0; k < 2; k++) begin
			{msg_rcvd_own, msg_sent} <= k[0] ? 2'h2 : 2'h1;
			@(posedge pclk);
			{msg_rcvd_own, msg_sent} <= 2'h0;
			repeat (2) @(posedge pclk);
			#1 chk("traffic on", traffic_led, 32'h1);
			repeat (8) @(posedge pclk);
			chk("traffic off", traffic_led, 32'h0);
		end
		guard_request <= 1'h1;
		@(posedge pclk);
		guard_request <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("guard off", lifetime_led, 32'h0);
		apb(1'h1, OFS_GUARD_TIME, 32'h5);
		apb(1'h1, OFS_LIFE_FACTOR, 32'h2);
		guard_request <= 1'h1;
		@(posedge pclk);
		guard_request <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("guard on", lifetime_led, 32'h1);
		life_timeout <= 1'h1;
		count(0, 16);
		chk("timeout flash", cnt, 32'h8);
		ctrl_error_passive <= 1'h1;
		count(1, 16);
		chk("passive flash", cnt, 32'h8);
		ctrl_bus_off <= 1'h1;
		repeat (3) @(posedge pclk);
		chk("bus off", {bus_error_led, bus_enable}, 32'h2);
		{ctrl_error_passive, ctrl_bus_off, life_timeout} <= 3'h0;
		$display("test monitors done");
		for (int k = 0; k < 4; k++) begin
			cmd <= cmds[k];
			count(2, 32);
			chk("fault pattern", cnt, lit[k]);
		end
		for (int k = 1; k < 3; k++) begin
			apb(1'h1, OFS_CTRL, k << CTRL_PDCFG_LSB);
			count(2, 32);
			chk("fault unused", cnt, 32'h0);
		end
		apb(1'h0, 8'h20, 32'h0);
		chk("unmapped err", err, 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("test faults done");
		rst(7'h00, 2'h0);
		repeat (16) @(posedge pclk);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk("zero addr", bus_enable, 32'h0);
		chk("zero status", rd, 32'h0);
		count(0, 16);
		chk("zero flash", cnt, 32'h8);
		$display("test zero address done");
		end_sim;
	end
endmodule
